// *** ecc_params.svh ***
// named offsets, field positions, reset values and timing figures for the common control block
`ifndef ECC_PARAMS_SVH
`define ECC_PARAMS_SVH

`define ECC_ADDR_CC2        8'h1A
`define ECC_ADDR_CC3        8'h1B
`define ECC_ADDR_CC4        8'hA8
`define ECC_ADDR_CC5        8'hAA
`define ECC_RESET_BYTE      8'h00

`define ECC_CC2_AUTO_AIS    5
`define ECC_CC2_AUTO_RA     4
`define ECC_CC2_MASK        8'h30

`define ECC_CC3_TX_ES_EN    7
`define ECC_CC3_BLOCK_SEL   6
`define ECC_CC3_IDLE_SEL    5
`define ECC_CC3_SIG_REINS   3
`define ECC_CC3_HW_SIG      2
`define ECC_CC3_RATE_SEL    1
`define ECC_CC3_ALT_LOSS    0
`define ECC_CC3_MASK        8'hEF

`define ECC_CC4_MASK        8'h9F
`define ECC_CC4_REMOTE_LB   7
`define ECC_CC5_MASK        8'h7F
`define ECC_CC5_RX_ALIGN    6
`define ECC_CC5_TX_ALIGN    5
`define ECC_CHSEL_MSB       4

`define ECC_ZEROS_NORMAL    12'h0FF
`define ECC_ZEROS_ALT       12'h800
`define ECC_CRC4_RA_MS      9'h080
`define ECC_CRC4_CONST_MS   9'h190
`define ECC_HALF_FRAME      6'h10

`define ECC_CLK_PERIOD_NS   40
`define ECC_MS_NS           1000000

`endif

// *** ecc_pkg.sv ***
// types shared by the common control block, its checker and its bench
package ecc_pkg;

    // receive-side alarm conditions that feed the automatic alarms
    typedef struct packed {
        logic frame_loss;
        logic ais_seen;
        logic carrier_loss;
    } ecc_rx_cond_t;

    // steering levels driven from the third and fourth common control registers
    typedef struct packed {
        logic tx_elastic_store_enable;
        logic tx_block_regs_function_select;
        logic tx_idle_regs_function_select;
        logic rx_signaling_reinsert_enable;
        logic tx_hw_signaling_insert_enable;
        logic tx_backplane_rate_select;
        logic remote_loopback;
    } ecc_ctrl_t;

    // multiframe search progress after FAS sync
    typedef enum logic [1:0] {
        ECC_MF_IDLE   = 2'b00,
        ECC_MF_SEARCH = 2'b01,
        ECC_MF_LATE   = 2'b10,
        ECC_MF_FAILED = 2'b11
    } ecc_mf_state_t;

endpackage

// *** ecc_chan_monitor.sv ***
// captures the byte of one selected channel as the channel stream passes by
`timescale 1ns/100ps
`include "ecc_params.svh"

module ecc_chan_monitor
    import ecc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic [4:0] chan_select,
    input  wire logic [4:0] chan_index,
    input  wire logic [7:0] chan_byte,
    input  wire logic       chan_strobe,
    output logic      [7:0] monitor_byte_q
);

    // only the matching channel slot overwrites the held byte
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            monitor_byte_q <= `ECC_RESET_BYTE;
        end else if (chan_strobe && (chan_index == chan_select)) begin
            monitor_byte_q <= chan_byte;
        end
    end

endmodule

// *** ecc_common_control.sv ***
// common control registers, automatic alarms, carrier loss and elastic store align for one framer
// Operation
// [R1] auto AIS enabled: send AIS on frame loss, incoming AIS or carrier loss
// [R2] auto remote alarm: frame loss, AIS, carrier loss, or no CRC4 multiframe in 128 ms
// [R3] no CRC4 multiframe sync within 400 ms: remote alarm sent continuously
// [R4] software never sets auto AIS and auto remote alarm enables together
// [R5] transmit elastic store bypassed when its enable is zero, used when one
// [R6] block-function bit one: block registers pick inserted signaling bits per channel
// [R7] idle-function bit: zero marks idle-code channels, one marks per-channel loopback
// [R8] software writes zero to every unassigned control bit
// [R9] re-insertion bit one puts signaling back into receive serial output
// [R10] software keeps hardware signaling insertion enable cleared
// [R11] backplane select zero for 1.544 MHz system clock, one for 2.048 MHz
// [R12] carrier loss after 255 zeros, or 2048 zeros with alternate criteria
// [R13] five-bit field picks transmit channel copied to transmit monitor byte
// [R14] five-bit field picks receive channel copied to receive monitor byte
// [R15] receive align rising edge separates pointers half a frame only if closer
// [R16] transmit align rising edge separates pointers half a frame only if closer
// [R17] toggle align bits only with stable system clock; clear then set again
// [R18] automatic alarms stop when triggers vanish or the enable is cleared
`timescale 1ns/100ps
`include "ecc_params.svh"

module ecc_common_control
    import ecc_pkg::*;
#(
    parameter int CYCLES_PER_MS = `ECC_MS_NS / `ECC_CLK_PERIOD_NS
)
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       cpu_cs,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    output logic      [7:0] cpu_rdata,
    output logic            cpu_rdata_valid,
    input  wire logic       rx_frame_loss,
    input  wire logic       rx_ais_seen,
    input  wire logic       rx_bit_valid,
    input  wire logic       rx_bit,
    input  wire logic       rx_crc4_enable,
    input  wire logic       rx_crc4_mf_sync,
    input  wire logic [5:0] rx_es_gap,
    input  wire logic [5:0] tx_es_gap,
    input  wire logic [4:0] tx_chan_index,
    input  wire logic [7:0] tx_chan_byte,
    input  wire logic       tx_chan_strobe,
    input  wire logic [4:0] rx_chan_index,
    input  wire logic [7:0] rx_chan_byte,
    input  wire logic       rx_chan_strobe,
    output logic            tx_send_ais,
    output logic            tx_send_remote_alarm,
    output logic            rx_carrier_loss,
    output ecc_ctrl_t       ctrl,
    output logic            rx_es_align,
    output logic            tx_es_align,
    output logic      [7:0] tx_monitor_byte,
    output logic      [7:0] rx_monitor_byte
);

    localparam logic [15:0] MS_LAST = 16'(CYCLES_PER_MS - 1);

    logic [7:0]    cc2_q;
    logic [7:0]    cc3_q;
    logic [7:0]    cc4_q;
    logic [7:0]    cc5_q;
    logic          rx_align_q;
    logic          tx_align_q;
    logic [11:0]   zero_run_q;
    logic          carrier_loss_q;
    logic [15:0]   ms_div_q;
    logic          ms_tick;
    logic [8:0]    mf_ms_q;
    ecc_mf_state_t mf_state_q;
    ecc_mf_state_t mf_state_d;
    ecc_rx_cond_t  cond;
    logic          any_cond;
    logic          write_hit;
    logic          read_hit;
    logic [11:0]   zero_limit;
    logic          ais_q;
    logic          ra_q;
    logic          rx_align_rise;
    logic          tx_align_rise;

    // a write and a read in one cycle both act; the read returns the old value
    assign write_hit = cpu_cs && cpu_wr;
    assign read_hit  = cpu_cs && cpu_rd;

    // register writes; unassigned bits are masked off so they always read zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cc2_q <= `ECC_RESET_BYTE;
            cc3_q <= `ECC_RESET_BYTE;
            cc4_q <= `ECC_RESET_BYTE;
            cc5_q <= `ECC_RESET_BYTE;
        end else if (write_hit) begin
            case (cpu_addr)
                `ECC_ADDR_CC2: cc2_q <= cpu_wdata & `ECC_CC2_MASK;
                `ECC_ADDR_CC3: cc3_q <= cpu_wdata & `ECC_CC3_MASK;
                `ECC_ADDR_CC4: cc4_q <= cpu_wdata & `ECC_CC4_MASK;
                `ECC_ADDR_CC5: cc5_q <= cpu_wdata & `ECC_CC5_MASK;
                default:       cc2_q <= cc2_q;
            endcase
        end
    end

    // read answer one cycle after the strobe; unmapped addresses answer zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpu_rdata       <= `ECC_RESET_BYTE;
            cpu_rdata_valid <= 1'b0;
        end else begin
            cpu_rdata_valid <= read_hit;
            if (read_hit) begin
                case (cpu_addr)
                    `ECC_ADDR_CC2: cpu_rdata <= cc2_q;
                    `ECC_ADDR_CC3: cpu_rdata <= cc3_q;
                    `ECC_ADDR_CC4: cpu_rdata <= cc4_q;
                    `ECC_ADDR_CC5: cpu_rdata <= cc5_q;
                    default:       cpu_rdata <= `ECC_RESET_BYTE;
                endcase
            end
        end
    end

    // steering levels straight from the third and fourth registers
    always_comb begin
        ctrl.tx_elastic_store_enable       = cc3_q[`ECC_CC3_TX_ES_EN];  // [R5]
        ctrl.tx_block_regs_function_select = cc3_q[`ECC_CC3_BLOCK_SEL]; // [R6]
        ctrl.tx_idle_regs_function_select  = cc3_q[`ECC_CC3_IDLE_SEL];  // [R7]
        ctrl.rx_signaling_reinsert_enable  = cc3_q[`ECC_CC3_SIG_REINS]; // [R9]
        // held for software only; the insertion path does not exist here
        ctrl.tx_hw_signaling_insert_enable = cc3_q[`ECC_CC3_HW_SIG];
        ctrl.tx_backplane_rate_select      = cc3_q[`ECC_CC3_RATE_SEL];
        ctrl.remote_loopback               = cc4_q[`ECC_CC4_REMOTE_LB];
    end

    // zero-run length depends on the alternate criteria bit
    assign zero_limit = cc3_q[`ECC_CC3_ALT_LOSS] ? `ECC_ZEROS_ALT : `ECC_ZEROS_NORMAL; // [R12]

    // consecutive zero counter; any valid one clears both the count and the loss flag
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            zero_run_q     <= 12'h000;
            carrier_loss_q <= 1'b0;
        end else if (rx_bit_valid) begin
            if (rx_bit) begin
                zero_run_q     <= 12'h000;
                carrier_loss_q <= 1'b0;
            end else begin
                if (zero_run_q != zero_limit) begin
                    zero_run_q <= zero_run_q + 12'h001;
                end
                // declared on the bit that completes the run
                if ((zero_run_q + 12'h001) >= zero_limit) begin
                    carrier_loss_q <= 1'b1; // [R12]
                end
            end
        end
    end

    assign rx_carrier_loss = carrier_loss_q;

    // one-millisecond tick; the divider is a parameter so simulation can shorten it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ms_div_q <= 16'h0000;
        end else if (ms_div_q >= MS_LAST) begin
            ms_div_q <= 16'h0000;
        end else begin
            ms_div_q <= ms_div_q + 16'h0001;
        end
    end

    assign ms_tick = (ms_div_q >= MS_LAST);

    // multiframe search after FAS sync: late at 128 ms, failed at 400 ms
    always_comb begin
        mf_state_d = mf_state_q;
        if (!rx_crc4_enable || rx_frame_loss || rx_crc4_mf_sync) begin
            mf_state_d = ECC_MF_IDLE;
        end else begin
            case (mf_state_q)
                ECC_MF_IDLE: begin
                    mf_state_d = ECC_MF_SEARCH;
                end
                ECC_MF_SEARCH: begin
                    if (ms_tick && (mf_ms_q + 9'h001) >= `ECC_CRC4_RA_MS) begin
                        mf_state_d = ECC_MF_LATE; // [R2]
                    end
                end
                ECC_MF_LATE: begin
                    if (ms_tick && (mf_ms_q + 9'h001) >= `ECC_CRC4_CONST_MS) begin
                        mf_state_d = ECC_MF_FAILED; // [R3]
                    end
                end
                ECC_MF_FAILED: begin
                    mf_state_d = ECC_MF_FAILED;
                end
                default: begin
                    mf_state_d = ECC_MF_IDLE;
                end
            endcase
        end
    end

    // search state register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mf_state_q <= ECC_MF_IDLE;
        end else begin
            mf_state_q <= mf_state_d;
        end
    end

    // milliseconds since FAS sync, held once the search has failed; restarts whenever the search restarts
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mf_ms_q <= 9'h000;
        end else if (mf_state_d == ECC_MF_IDLE) begin
            mf_ms_q <= 9'h000;
        end else if (ms_tick && mf_state_q != ECC_MF_FAILED) begin
            mf_ms_q <= mf_ms_q + 9'h001;
        end
    end

    assign cond.frame_loss   = rx_frame_loss;
    assign cond.ais_seen     = rx_ais_seen;
    assign cond.carrier_loss = carrier_loss_q;
    assign any_cond          = |cond;

    // auto AIS follows its causes every cycle, so it drops one cycle after they go
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ais_q <= 1'b0;
        end else begin
            ais_q <= cc2_q[`ECC_CC2_AUTO_AIS] && any_cond; // [R1] [R18]
        end
    end

    // remote alarm also covers a late or failed multiframe search; with both enables
    // set, an illegal setting, both alarms are sent rather than one being picked
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ra_q <= 1'b0;
        end else begin
            ra_q <= cc2_q[`ECC_CC2_AUTO_RA]
                    && (any_cond || mf_state_q == ECC_MF_LATE
                        || mf_state_q == ECC_MF_FAILED); // [R2] [R3] [R18]
        end
    end

    assign tx_send_ais          = ais_q;
    assign tx_send_remote_alarm = ra_q;

    // align bits act only on a rising edge; holding them high does nothing more
    assign rx_align_rise = cc5_q[`ECC_CC5_RX_ALIGN] && !rx_align_q;
    assign tx_align_rise = cc5_q[`ECC_CC5_TX_ALIGN] && !tx_align_q;

    // receive align pulse, only when the pointers sit closer than half a frame
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_align_q  <= 1'b0;
            rx_es_align <= 1'b0;
        end else begin
            rx_align_q  <= cc5_q[`ECC_CC5_RX_ALIGN];
            rx_es_align <= rx_align_rise && (rx_es_gap < `ECC_HALF_FRAME); // [R15]
        end
    end

    // transmit align pulse; the store moves its pointers itself and loses data then
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_align_q  <= 1'b0;
            tx_es_align <= 1'b0;
        end else begin
            tx_align_q  <= cc5_q[`ECC_CC5_TX_ALIGN];
            tx_es_align <= tx_align_rise && (tx_es_gap < `ECC_HALF_FRAME); // [R16]
        end
    end

    // transmit channel monitor follows the fourth register's select field
    ecc_chan_monitor u_tx_monitor (
        .sys_clk        (sys_clk),
        .srst           (srst),
        .chan_select    (cc4_q[`ECC_CHSEL_MSB:0]), // [R13]
        .chan_index     (tx_chan_index),
        .chan_byte      (tx_chan_byte),
        .chan_strobe    (tx_chan_strobe),
        .monitor_byte_q (tx_monitor_byte)
    );

    // receive channel monitor follows the fifth register's select field
    ecc_chan_monitor u_rx_monitor (
        .sys_clk        (sys_clk),
        .srst           (srst),
        .chan_select    (cc5_q[`ECC_CHSEL_MSB:0]), // [R14]
        .chan_index     (rx_chan_index),
        .chan_byte      (rx_chan_byte),
        .chan_strobe    (rx_chan_strobe),
        .monitor_byte_q (rx_monitor_byte)
    );

endmodule

// *** ecc_line_model.sv ***
// line side bit source: a run of equal bits, one bit every second cycle
`timescale 1ns/100ps
module ecc_line_model (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        go,
    input  wire logic [11:0] n_bits,
    input  wire logic        bit_val,
    output logic             rx_bit_valid,
    output logic             rx_bit,
    output logic             busy
);
    logic [12:0] left_q;
    logic        val_q;
    // half-bit phase counter; odd phases carry a valid bit
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            left_q <= 13'h0000;
            val_q  <= 1'b0;
        end else if (go) begin
            left_q <= {n_bits, 1'b0};
            val_q  <= bit_val;
        end else if (left_q != 13'h0000) begin
            left_q <= left_q - 13'h0001;
        end
    end
    // between bits the line shows the opposite level so a stale value never passes
    assign rx_bit_valid = left_q[0];
    assign rx_bit       = left_q[0] ? val_q : !val_q;
    assign busy         = left_q != 13'h0000;
endmodule

// *** ecc_common_control_chk.sv ***
// assertions on the ports of the common control block
`timescale 1ns/100ps
module ecc_common_control_chk
    import ecc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       cpu_cs,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       cpu_rdata_valid,
    input  wire logic       rx_frame_loss,
    input  wire logic       rx_ais_seen,
    input  wire logic       rx_bit_valid,
    input  wire logic       rx_bit,
    input  wire logic [5:0] rx_es_gap,
    input  wire logic [4:0] tx_chan_index,
    input  wire logic [7:0] tx_chan_byte,
    input  wire logic       tx_chan_strobe,
    input  wire logic       tx_send_ais,
    input  wire logic       tx_send_remote_alarm,
    input  wire logic       rx_carrier_loss,
    input  wire ecc_ctrl_t  ctrl,
    input  wire logic       rx_es_align,
    input  wire logic       tx_es_align,
    input  wire logic [7:0] tx_monitor_byte
);
    logic [7:0]  c2_q, c3_q, c4_q, c5_q;
    logic [11:0] zc_q;
    logic        wr_s;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    assign wr_s = cpu_cs && cpu_wr;
    // shadow control bytes, so the checks need no view inside the block
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            c2_q <= 8'h00;
            c3_q <= 8'h00;
            c4_q <= 8'h00;
            c5_q <= 8'h00;
        end else if (wr_s) begin
            if (cpu_addr == 8'h1A) c2_q <= cpu_wdata;
            if (cpu_addr == 8'h1B) c3_q <= cpu_wdata;
            if (cpu_addr == 8'hA8) c4_q <= cpu_wdata;
            if (cpu_addr == 8'hAA) c5_q <= cpu_wdata;
        end
    end
    // run of consecutive zeros seen on the line, saturating
    always_ff @(posedge sys_clk) begin
        if (srst || (rx_bit_valid && rx_bit)) begin
            zc_q <= 12'h000;
        end else if (rx_bit_valid && zc_q != 12'hFFF) begin
            zc_q <= zc_q + 12'h001;
        end
    end
    chk_ais_on: assert property ((c2_q[5] && (rx_frame_loss || rx_ais_seen
        || rx_carrier_loss)) |=> tx_send_ais) else $error("ais not sent");
    chk_ais_off: assert property (!c2_q[5] |=> !tx_send_ais)
        else $error("ais sent while disabled");
    chk_ra_on: assert property ((c2_q[4] && rx_frame_loss) |=> tx_send_remote_alarm)
        else $error("remote alarm not sent");
    chk_rd_valid: assert property ((cpu_cs && cpu_rd) |=> cpu_rdata_valid)
        else $error("read not answered");
    chk_ctrl_write: assert property ((wr_s && cpu_addr == 8'h1B) |=>
        ctrl[6:1] == {$past(cpu_wdata[7:5]), $past(cpu_wdata[3:1])}) else $error("ctrl wrong");
    chk_cl_set: assert property ((rx_bit_valid && !rx_bit
        && zc_q == (c3_q[0] ? 12'h7FF : 12'h0FE)) |=> rx_carrier_loss) else $error("no loss");
    chk_cl_early: assert property ($rose(rx_carrier_loss) |->
        zc_q >= (c3_q[0] ? 12'h800 : 12'h0FF)) else $error("carrier loss too early");
    chk_rx_align: assert property ((wr_s && cpu_addr == 8'hAA && cpu_wdata[6]
        && !c5_q[6] && rx_es_gap < 6'h10) |-> ##2 rx_es_align) else $error("no rx align");
    chk_tx_edge: assert property (tx_es_align |-> $past(c5_q[5]) && !$past(c5_q[5], 2))
        else $error("tx align without rising bit");
    chk_tx_mon: assert property ((tx_chan_strobe && tx_chan_index == c4_q[4:0])
        |=> tx_monitor_byte == $past(tx_chan_byte)) else $error("monitor byte wrong");
endmodule
bind ecc_common_control ecc_common_control_chk ecc_common_control_chk_i (.*);

// *** tb.sv ***
// self-checking bench for the common control block
`timescale 1ns/100ps
module tb;
    import ecc_pkg::*;
    logic       sys_clk = 1'b0;
    logic       srst, cpu_cs, cpu_wr, cpu_rd, rx_frame_loss, rx_ais_seen, go, bit_val;
    logic       rx_crc4_enable, rx_crc4_mf_sync, tx_chan_strobe, rx_chan_strobe;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, tx_chan_byte, rx_chan_byte, tx_mon, rx_mon;
    logic [5:0] rx_es_gap, tx_es_gap;
    logic [4:0] tx_chan_index, rx_chan_index;
    logic [11:0] n_bits;
    logic       rdv, rx_bit_valid, rx_bit, busy, ais, ra, cl, rxa, txa;
    ecc_ctrl_t  ctrl;
    int         n_fail = 0;
    int         compares = 0;
    logic [7:0] adr [4] = '{8'h1A, 8'h1B, 8'hA8, 8'hAA};
    logic [7:0] val [4] = '{8'h20, 8'hEB, 8'h9F, 8'h7F};
    logic [7:0] one [5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h02};
    always #20 sys_clk = ~sys_clk;
    ecc_common_control #(.CYCLES_PER_MS(2)) ecc_common_control_i (
        .sys_clk(sys_clk), .srst(srst), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rdata_valid(rdv), .rx_frame_loss(rx_frame_loss), .rx_ais_seen(rx_ais_seen),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_crc4_enable(rx_crc4_enable),
        .rx_crc4_mf_sync(rx_crc4_mf_sync), .rx_es_gap(rx_es_gap), .tx_es_gap(tx_es_gap),
        .tx_chan_index(tx_chan_index), .tx_chan_byte(tx_chan_byte),
        .tx_chan_strobe(tx_chan_strobe), .rx_chan_index(rx_chan_index),
        .rx_chan_byte(rx_chan_byte), .rx_chan_strobe(rx_chan_strobe), .tx_send_ais(ais),
        .tx_send_remote_alarm(ra), .rx_carrier_loss(cl), .ctrl(ctrl), .rx_es_align(rxa),
        .tx_es_align(txa), .tx_monitor_byte(tx_mon), .rx_monitor_byte(rx_mon));
    ecc_line_model ecc_line_model_i (.sys_clk(sys_clk), .srst(srst), .go(go),
        .n_bits(n_bits), .bit_val(bit_val), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .busy(busy));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {cpu_cs, cpu_wr, cpu_addr, cpu_wdata} = {2'b11, a, d};
        @(negedge sys_clk);
        {cpu_cs, cpu_wr} = 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        {cpu_cs, cpu_rd, cpu_addr} = {2'b11, a};
        @(negedge sys_clk);
        {cpu_cs, cpu_rd} = 2'b00;
        chk({7'h00, rdv}, 8'h01, "read valid");
        chk(cpu_rdata, exp, "read data");
    endtask
    // a run of bits from the line model, waited on with a bound
    task automatic send(input logic [11:0] n, input logic v, input logic [7:0] exp);
        @(negedge sys_clk);
        {go, n_bits, bit_val} = {1'b1, n, v};
        @(negedge sys_clk);
        go = 1'b0;
        for (int k = 0; k < 5000 && busy; k++) @(negedge sys_clk);
        chk({7'h00, cl}, exp, "carrier loss");
    endtask
    initial begin
        {srst, cpu_cs, cpu_wr, cpu_rd, rx_frame_loss, rx_ais_seen, go, bit_val} = 8'h80;
        {rx_crc4_enable, rx_crc4_mf_sync, tx_chan_strobe, rx_chan_strobe} = 4'h0;
        {cpu_addr, cpu_wdata, tx_chan_byte, rx_chan_byte, n_bits} = 44'h0;
        {rx_es_gap, tx_es_gap, tx_chan_index, rx_chan_index} = 22'h0;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        // reset values, an unmapped hole, then legal patterns with spare bits kept zero
        foreach (adr[i]) rd(adr[i], 8'h00);
        rd(8'h55, 8'h00);
        foreach (adr[i]) begin
            wr(adr[i], val[i]);
            rd(adr[i], val[i]);
        end
        chk({1'b0, ctrl}, 8'h7B, "ctrl all");
        foreach (one[i]) begin
            wr(8'h1B, one[i]);
            chk({1'b0, ctrl}, {1'b0, one[i][7:5], one[i][3:1], 1'b1}, "cc3 bit");
        end
        // carrier loss with alternate then normal count; auto ais follows it
        wr(8'h1B, 8'h01);
        send(12'd2047, 1'b0, 8'h00);
        send(12'd1, 1'b0, 8'h01);
        @(negedge sys_clk);
        chk({7'h00, ais}, 8'h01, "ais on carrier loss");
        send(12'd1, 1'b1, 8'h00);
        wr(8'h1B, 8'h00);
        send(12'd254, 1'b0, 8'h00);
        send(12'd1, 1'b0, 8'h01);
        send(12'd1, 1'b1, 8'h00);
        // frame loss and incoming AIS, each with one enable at a time, never both
        for (int j = 0; j < 2; j++) begin
            wr(8'h1A, j ? 8'h10 : 8'h20);
            for (int i = 0; i < 2; i++) begin
                {rx_ais_seen, rx_frame_loss} = 2'b01 << i;
                @(negedge sys_clk);
                chk({6'h00, ais, ra}, j ? 8'h01 : 8'h02, "alarm on cause");
                {rx_ais_seen, rx_frame_loss} = 2'b00;
                @(negedge sys_clk);
                chk({6'h00, ais, ra}, 8'h00, "alarm cleared");
            end
            rx_frame_loss = 1'b1;
            wr(8'h1A, 8'h00);
            @(negedge sys_clk);
            chk({6'h00, ais, ra}, 8'h00, "alarm disabled");
            rx_frame_loss = 1'b0;
        end
        // multiframe search: 128 ms is 256 cycles and 400 ms is 800 cycles here
        wr(8'h1A, 8'h10);
        rx_crc4_enable = 1'b1;
        repeat (238) @(negedge sys_clk);
        chk({7'h00, ra}, 8'h00, "ra before 128 ms");
        repeat (40) @(negedge sys_clk);
        chk({7'h00, ra}, 8'h01, "ra after 128 ms");
        repeat (560) @(negedge sys_clk);
        chk({7'h00, ra}, 8'h01, "ra after 400 ms");
        rx_crc4_mf_sync = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({7'h00, ra}, 8'h00, "ra after sync");
        wr(8'h1A, 8'h00);
        // align only on a rising bit and only when pointers are closer than half a frame
        for (int i = 0; i < 2; i++) begin
            {rx_es_gap, tx_es_gap} = i ? {6'h10, 6'h0F} : {6'h05, 6'h14};
            wr(8'hAA, 8'h00);
            wr(8'hAA, 8'h60);
            @(negedge sys_clk);
            chk({6'h00, rxa, txa}, i ? 8'h01 : 8'h02, "align pulse");
            wr(8'hAA, 8'h60);
            @(negedge sys_clk);
            chk({6'h00, rxa, txa}, 8'h00, "no realign");
        end
        // channel monitors: transmit channel 5, receive channel 9
        wr(8'hA8, 8'h05);
        wr(8'hAA, 8'h09);
        for (int c = 0; c < 32; c++) begin
            @(negedge sys_clk);
            {tx_chan_strobe, rx_chan_strobe, tx_chan_index, rx_chan_index} = {2'b11, {2{c[4:0]}}};
            {tx_chan_byte, rx_chan_byte} = {c[7:0] ^ 8'hA5, c[7:0] ^ 8'h3C};
        end
        @(negedge sys_clk);
        {tx_chan_strobe, rx_chan_strobe} = 2'b00;
        @(negedge sys_clk);
        chk(tx_mon, 8'hA0, "tx monitor");
        chk(rx_mon, 8'h35, "rx monitor");
        finish_test();
    end
    // about five times the expected run length
    initial begin
        #(40 * 30000);
        n_fail++;
        finish_test();
    end
endmodule
